// File: bench/rtcas_host.sv
/*
 * rtcas_host: apb master model standing in for host software.
 * assumes: single pclk; the slave answers every access with pready.
 */
`timescale 1ns/1ps
module rtcas_host (
    // clock
    input  wire logic        pclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer: setup, access held until pready or for at most 64 cycles, then release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        ok  = (n < 64);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask
endmodule

// File: bench/rtcas_sched_bench.sv
/*
 * rtcas_sched_bench: register, fault and run checks of the scheduler slot.
 * assumes: rtcas_host drives apb; bench drives rtc_now and minute_tick.
 */
`timescale 1ns/1ps
module rtcas_sched_bench;
    import rtcas_pkg::*;
    localparam logic [5:0] A_HOST = PG_ACT + IDX_HOST_ACTION;
    localparam logic [5:0] A_AUX  = PG_ACT + IDX_AUX_ACTION;
    localparam logic [5:0] A_REL  = PG_ACT + IDX_RELAY_ACTION;
    localparam logic [5:0] A_SEL  = PG_GLOB + IDX_SLOT_SELECTOR;
    localparam logic [5:0] A_TYP  = PG_GLOB + IDX_SCHED_TYPE;
    localparam logic [5:0] A_STS  = PG_GLOB + IDX_IRQ_STATUS;
    localparam logic [5:0] A_MSK  = PG_GLOB + IDX_IRQ_MASK;
    localparam logic [5:0] A_ARM  = PG_START + IDX_SLOT_ARM;
    localparam logic [5:0] A_SF   = PG_START + IDX_START_FAULT;
    localparam logic [5:0] A_RF   = PG_RUN + IDX_RUN_FAULT;
    localparam logic [5:0] A_LEN  = PG_RUN + IDX_RUN_LENGTH;
    localparam logic [5:0] A_REP  = PG_RUN + IDX_REPEAT_PERIOD;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, minute_tick, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        erv, okv;
    rtcas_time_s rtc_now, t0, t1;
    rtcas_act_s  action_out;
    int          err_count, total_checks;
    logic [5:0]  rst_i[10] = '{A_HOST, A_AUX, A_REL, A_SEL, A_TYP, A_STS, A_MSK, A_ARM,
                               A_LEN, A_REP};
    logic [5:0]  f_i[5] = '{IDX_START_MINUTE, IDX_START_HOUR, IDX_START_DAY,
                            IDX_START_MONTH, IDX_START_YEAR};
    logic [7:0]  f_ok[5] = '{8'h59, 8'h23, 8'h31, 8'h12, 8'h24};
    logic [7:0]  f_bad[5] = '{8'h60, 8'h24, 8'h00, 8'h13, 8'h9a};

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    rtcas_host rtcas_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rtcas_sched rtcas_sched_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_now(rtc_now),
        .minute_tick(minute_tick), .action_out(action_out), .irq(irq));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] i, input logic [31:0] d);
        rtcas_host_i.xfer(w, {i, 2'b00}, d, rdv, erv, okv);
        if (okv !== 1'b1) begin
            err_count++;
            $display("ERROR %0t no pready at index %h", $time, i);
            end_of_test();
        end
    endtask
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        acc(1'b1, i, d);
    endtask
    task automatic rd(input logic [5:0] i, input logic [31:0] e);
        acc(1'b0, i, 32'h0);
        chk(rdv, e, "read");
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic tick(input rtcas_time_s t, input int n);
        @(posedge pclk);
        rtc_now <= t;
        repeat (n) begin
            @(posedge pclk);
            minute_tick <= 1'b1;
            @(posedge pclk);
            minute_tick <= 1'b0;
        end
        settle();
    endtask

    initial begin
        presetn = 1'b0;
        minute_tick = 1'b0;
        rtc_now = '0;
        err_count = 0;
        total_checks = 0;
        t0 = '{year: 8'h24, month: 8'h12, day: 8'h31, hour: 8'h23, minute: 8'h59};
        t1 = t0;
        t1.minute = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_i[k]) rd(rst_i[k], 32'h0);
        $display("test reset done");
        wr(A_HOST, ACT_ON);
        rd(A_HOST, 32'h1);
        wr(A_SEL, 32'h4);
        rd(A_SEL, 32'h0);
        wr(A_SEL, 32'h1);
        wr(IDX_START_MINUTE, 32'h07);
        rd(IDX_START_MINUTE, 32'h07);
        wr(A_SEL, 32'h0);
        rd(IDX_START_MINUTE, 32'h0);
        wr(A_TYP, 32'h2);
        rd(A_TYP, 32'h0);
        acc(1'b0, 6'h3f, 32'h0);
        chk({31'h0, erv}, 32'h1, "unmapped error");
        $display("test access done");
        foreach (f_i[k]) wr(PG_START + f_i[k], f_ok[k]);
        wr(A_LEN, 32'h0002);
        rd(A_SF, 32'h0);
        foreach (f_i[k]) begin
            wr(PG_START + f_i[k], f_bad[k]);
            rd(A_SF, 32'h1 << k);
            wr(PG_START + f_i[k], f_ok[k]);
        end
        wr(A_LEN, 32'h0);
        rd(A_RF, 32'h1 << FLT_LENGTH);
        wr(A_ARM, ARM_START);
        rd(A_STS, 32'h1 << IRQ_FAULT);
        wr(A_STS, 32'h7);
        rd(A_STS, 32'h0);
        wr(A_LEN, 32'h0002);
        $display("test fault done");
        wr(A_TYP, SCHED_SLOT);
        wr(A_AUX, ACT_OFF);
        wr(A_REL, ACT_ON);
        wr(A_MSK, 32'h3);
        wr(A_ARM, ARM_START);
        tick(t0, 1);
        chk({29'h0, action_out}, 32'h5, "run start");
        chk({31'h0, irq}, 32'h1, "irq begin");
        rd(A_STS, 32'h1 << IRQ_BEGIN);
        rd(PG_GLOB + IDX_SLOT_RUNNING, 32'h1);
        wr(A_MSK, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(A_MSK, 32'h3);
        wr(A_STS, 32'h1 << IRQ_BEGIN);
        settle();
        chk({31'h0, irq}, 32'h0, "irq cleared");
        tick(t1, 2);
        chk({29'h0, action_out}, 32'h0, "run end");
        chk({31'h0, irq}, 32'h1, "irq end");
        rd(A_STS, 32'h1 << IRQ_END);
        tick(t1, 12);
        chk({29'h0, action_out}, 32'h0, "no repeat");
        $display("test once done");
        wr(A_LEN, 32'h0001);
        wr(A_REP, 32'h0010);
        wr(A_ARM, ARM_START);
        tick(t0, 1);
        chk({29'h0, action_out}, 32'h5, "repeat start");
        tick(t1, 9);
        chk({29'h0, action_out}, 32'h0, "repeat gap");
        tick(t1, 1);
        chk({29'h0, action_out}, 32'h5, "repeat again");
        wr(A_ARM, ARM_STOP);
        settle();
        chk({29'h0, action_out}, 32'h0, "stopped");
        wr(A_ARM, ARM_START);
        tick(t0, 1);
        wr(A_TYP, SCHED_BASIC);
        settle();
        chk({29'h0, action_out}, 32'h0, "basic selected");
        $display("test repeat done");
        end_of_test();
    end
endmodule

// File: common/rtcas_pkg.sv
/*
 * rtcas_pkg: register map, field codes, carriers and bcd helpers for the
 * calendar action scheduler slot block.
 * assumes: apb word addressing, byte address = 4 * word index.
 */
package rtcas_pkg;

    // word indices: page base plus in-page offset
    localparam logic [5:0] PG_START           = 6'h00;
    localparam logic [5:0] PG_RUN             = 6'h08;
    localparam logic [5:0] PG_ACT             = 6'h10;
    localparam logic [5:0] PG_GLOB            = 6'h18;
    localparam logic [5:0] IDX_SLOT_ARM       = 6'h00;
    localparam logic [5:0] IDX_START_MINUTE   = 6'h01;
    localparam logic [5:0] IDX_START_HOUR     = 6'h02;
    localparam logic [5:0] IDX_START_DAY      = 6'h03;
    localparam logic [5:0] IDX_START_MONTH    = 6'h04;
    localparam logic [5:0] IDX_START_YEAR     = 6'h05;
    localparam logic [5:0] IDX_START_FAULT    = 6'h06;
    localparam logic [5:0] IDX_RUN_FAULT      = 6'h00;
    localparam logic [5:0] IDX_RUN_LENGTH     = 6'h01;
    localparam logic [5:0] IDX_REPEAT_PERIOD  = 6'h03;
    localparam logic [5:0] IDX_HOST_ACTION    = 6'h00;
    localparam logic [5:0] IDX_AUX_ACTION     = 6'h01;
    localparam logic [5:0] IDX_RELAY_ACTION   = 6'h02;
    localparam logic [5:0] IDX_SLOT_SELECTOR  = 6'h00;
    localparam logic [5:0] IDX_SCHED_TYPE     = 6'h01;
    localparam logic [5:0] IDX_IRQ_STATUS     = 6'h02;
    localparam logic [5:0] IDX_IRQ_MASK       = 6'h03;
    localparam logic [5:0] IDX_SLOT_RUNNING   = 6'h04;

    // field codes and reset values
    localparam logic [7:0]  ARM_START         = 8'hff;
    localparam logic [7:0]  ARM_STOP          = 8'h00;
    localparam logic [7:0]  ACT_ON            = 8'h01;
    localparam logic [7:0]  ACT_OFF           = 8'h00;
    localparam logic [7:0]  SCHED_BASIC       = 8'h00;
    localparam logic [7:0]  SCHED_SLOT        = 8'h01;
    localparam logic [15:0] REPEAT_ONCE       = 16'h0000;
    localparam logic [7:0]  BYTE_RESET        = 8'h00;
    localparam logic [15:0] WORD_RESET        = 16'h0000;

    // fault byte bit positions
    localparam int FLT_MINUTE = 0;
    localparam int FLT_HOUR   = 1;
    localparam int FLT_DAY    = 2;
    localparam int FLT_MONTH  = 3;
    localparam int FLT_YEAR   = 4;
    localparam int FLT_LENGTH = 5;
    localparam int FLT_REPEAT = 6;

    // interrupt status bit positions
    localparam int IRQ_BEGIN  = 0;
    localparam int IRQ_END    = 1;
    localparam int IRQ_FAULT  = 2;
    localparam int IRQ_BITS   = 3;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
    } rtcas_time_s;

    typedef struct packed {
        logic host;
        logic aux;
        logic relay;
    } rtcas_act_s;

    // two-digit bcd within [lo, hi]
    function automatic logic rtcas_bcd_ok(input logic [7:0] v, input logic [6:0] lo,
                                          input logic [6:0] hi);
        logic [6:0] b;
        b = 7'(v[7:4] * 4'd10) + 7'(v[3:0]);
        return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (b >= lo) && (b <= hi);
    endfunction

    function automatic logic rtcas_bcd16_ok(input logic [15:0] v);
        return (v[15:12] <= 4'h9) && (v[11:8] <= 4'h9) && (v[7:4] <= 4'h9)
            && (v[3:0] <= 4'h9);
    endfunction

    function automatic logic [13:0] rtcas_bcd16_bin(input logic [15:0] v);
        return 14'(v[15:12] * 10'd1000) + 14'(v[11:8] * 7'd100)
             + 14'(v[7:4] * 4'd10) + 14'(v[3:0]);
    endfunction

endpackage

// File: hw/rtcas_sched.sv
/*
 * rtcas_sched: calendar action scheduler with four schedule slots behind an
 * apb slave, sticky interrupt status with mask and one level interrupt.
 * assumes: rtc_now is the current bcd calendar time, minute_tick pulses one
 * cycle when the minute changes; all inputs synchronous to pclk.
 */
// Summary of operation
// (R1) arm byte 0xff starts the selected slot, 0x00 stops it
// (R2) start minute is bcd 0 to 59 and is matched against the clock
// (R3) start hour is bcd 0 to 23 and is matched against the clock
// (R4) start day is bcd 1 to 31 and is matched against the clock
// (R5) start month is bcd 1 to 12 and is matched against the clock
// (R6) start year is bcd 0 to 99 and is matched against the clock
// (R7) run length is four bcd digits of minutes, 1 to 9999
// (R8) repetition 0x0000 runs the actions once for the run length
// (R9) repetition 0x0001 to 0x9999 repeats every n decimal minutes
// (R10) only the power-up-system trigger exists and is always selected
// (R11) host power action resets to 0x00; 0x01 arms, 0x00 disarms it
// (R12) aux power action resets to 0x00; 0x01 arms, 0x00 disarms it
// (R13) relay set action resets to 0x00; 0x01 arms, 0x00 disarms it
// (R14) slot selector picks slot 0 to 3 for access; resets to 0
// (R15) scheduler type 0x00 basic (default) or 0x01 slot scheduler
// (R16) armed slot matching the time asserts enabled actions for the run
`timescale 1ns/1ps
module rtcas_sched
    import rtcas_pkg::*;
#(
    parameter int SLOTS  = 4,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // time base
    input  wire rtcas_time_s       rtc_now,
    input  wire logic              minute_tick,
    // actions and interrupt
    output rtcas_act_s             action_out,
    output logic                   irq
);
    localparam int SW = $clog2(SLOTS);

    logic [7:0]        slot_arm          [SLOTS];
    rtcas_time_s       start_time        [SLOTS];
    logic [15:0]       run_length_minutes    [SLOTS];
    logic [15:0]       repeat_period_minutes [SLOTS];
    logic [7:0]        host_power_on_action  [SLOTS];
    logic [7:0]        aux_power_on_action   [SLOTS];
    logic [7:0]        relay_set_action      [SLOTS];
    logic [13:0]       run_left          [SLOTS];
    logic [13:0]       period_left       [SLOTS];
    logic [SLOTS-1:0]  running;
    logic [SLOTS-1:0]  started;
    logic [SLOTS-1:0]  begin_hit;
    logic [SLOTS-1:0]  end_hit;
    logic [SLOTS-1:0]  repeat_hit;
    logic [6:0]        fault             [SLOTS];
    logic [SW-1:0]     slot_selector;
    logic [7:0]        sched_type;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_event;
    logic [5:0]        widx;
    logic              setup;
    logic              wr_en;
    logic [7:0]        wbyte;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    rtcas_act_s        next_action;

    assign widx  = paddr[7:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign wbyte = pwdata[7:0];

    // one wait-free answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && next_pslverr;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // read mux and unmapped decode
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (widx)
            PG_START + IDX_SLOT_ARM:      next_prdata[7:0]  = slot_arm[slot_selector];
            PG_START + IDX_START_MINUTE:  next_prdata[7:0]  = start_time[slot_selector].minute;
            PG_START + IDX_START_HOUR:    next_prdata[7:0]  = start_time[slot_selector].hour;
            PG_START + IDX_START_DAY:     next_prdata[7:0]  = start_time[slot_selector].day;
            PG_START + IDX_START_MONTH:   next_prdata[7:0]  = start_time[slot_selector].month;
            PG_START + IDX_START_YEAR:    next_prdata[7:0]  = start_time[slot_selector].year;
            PG_START + IDX_START_FAULT:   next_prdata[6:0]  = fault[slot_selector];
            PG_RUN + IDX_RUN_FAULT:       next_prdata[6:0]  = fault[slot_selector];
            PG_RUN + IDX_RUN_LENGTH:      next_prdata[15:0] = run_length_minutes[slot_selector];
            PG_RUN + IDX_REPEAT_PERIOD:   next_prdata[15:0] = repeat_period_minutes[slot_selector];
            PG_ACT + IDX_HOST_ACTION:     next_prdata[7:0]  = host_power_on_action[slot_selector];
            PG_ACT + IDX_AUX_ACTION:      next_prdata[7:0]  = aux_power_on_action[slot_selector];
            PG_ACT + IDX_RELAY_ACTION:    next_prdata[7:0]  = relay_set_action[slot_selector];
            PG_GLOB + IDX_SLOT_SELECTOR:  next_prdata[SW-1:0] = slot_selector;
            PG_GLOB + IDX_SCHED_TYPE:     next_prdata[7:0]  = sched_type;
            PG_GLOB + IDX_IRQ_STATUS:     next_prdata[IRQ_BITS-1:0] = irq_status;
            PG_GLOB + IDX_IRQ_MASK:       next_prdata[IRQ_BITS-1:0] = irq_mask;
            PG_GLOB + IDX_SLOT_RUNNING:   next_prdata[SLOTS-1:0] = running;
            default:                      next_pslverr = 1'b1;
        endcase
    end

    // slot programming, always into the selected slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_arm[i]              <= ARM_STOP;
                start_time[i]            <= '0;
                run_length_minutes[i]    <= WORD_RESET;
                repeat_period_minutes[i] <= REPEAT_ONCE;
                host_power_on_action[i]  <= ACT_OFF;  // [R11]
                aux_power_on_action[i]   <= ACT_OFF;  // [R12]
                relay_set_action[i]      <= ACT_OFF;  // [R13]
            end
        end else if (wr_en) begin
            unique case (widx)
                PG_START + IDX_SLOT_ARM:     slot_arm[slot_selector] <= wbyte;  // [R1]
                PG_START + IDX_START_MINUTE: start_time[slot_selector].minute <= wbyte;  // [R2]
                PG_START + IDX_START_HOUR:   start_time[slot_selector].hour <= wbyte;  // [R3]
                PG_START + IDX_START_DAY:    start_time[slot_selector].day <= wbyte;  // [R4]
                PG_START + IDX_START_MONTH:  start_time[slot_selector].month <= wbyte;  // [R5]
                PG_START + IDX_START_YEAR:   start_time[slot_selector].year <= wbyte;  // [R6]
                PG_RUN + IDX_RUN_LENGTH:     run_length_minutes[slot_selector] <= pwdata[15:0];  // [R7]
                PG_RUN + IDX_REPEAT_PERIOD:  repeat_period_minutes[slot_selector] <= pwdata[15:0];
                PG_ACT + IDX_HOST_ACTION:    host_power_on_action[slot_selector] <= wbyte;  // [R11]
                PG_ACT + IDX_AUX_ACTION:     aux_power_on_action[slot_selector] <= wbyte;  // [R12]
                PG_ACT + IDX_RELAY_ACTION:   relay_set_action[slot_selector] <= wbyte;  // [R13]
                default: ;
            endcase
        end
    end

    // slot selector accepts only existing slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_selector <= '0;  // [R14]
        end else if (wr_en && widx == PG_GLOB + IDX_SLOT_SELECTOR && wbyte < 8'(SLOTS)) begin
            slot_selector <= SW'(wbyte);  // [R14]
        end
    end

    // scheduler type: only the two codes are taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sched_type <= SCHED_BASIC;  // [R15]
        end else if (wr_en && widx == PG_GLOB + IDX_SCHED_TYPE
                     && (wbyte == SCHED_BASIC || wbyte == SCHED_SLOT)) begin
            sched_type <= wbyte;  // [R15]
        end
    end

    // per-slot fault byte from field range checks
    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            fault[i][FLT_MINUTE] = !rtcas_bcd_ok(start_time[i].minute, 7'd0, 7'd59);  // [R2]
            fault[i][FLT_HOUR]   = !rtcas_bcd_ok(start_time[i].hour, 7'd0, 7'd23);  // [R3]
            fault[i][FLT_DAY]    = !rtcas_bcd_ok(start_time[i].day, 7'd1, 7'd31);  // [R4]
            fault[i][FLT_MONTH]  = !rtcas_bcd_ok(start_time[i].month, 7'd1, 7'd12);  // [R5]
            fault[i][FLT_YEAR]   = !rtcas_bcd_ok(start_time[i].year, 7'd0, 7'd99);  // [R6]
            fault[i][FLT_LENGTH] = !rtcas_bcd16_ok(run_length_minutes[i])
                                   || run_length_minutes[i] == WORD_RESET;  // [R7]
            fault[i][FLT_REPEAT] = !rtcas_bcd16_ok(repeat_period_minutes[i]);  // [R9]
        end
    end

    // minute-tick decisions per slot
    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            logic go;
            go = sched_type == SCHED_SLOT && slot_arm[i] == ARM_START
                 && fault[i] == '0 && minute_tick;  // [R1] [R15]
            begin_hit[i]  = go && !started[i] && rtc_now == start_time[i];  // [R16]
            repeat_hit[i] = go && started[i] && repeat_period_minutes[i] != REPEAT_ONCE
                            && period_left[i] <= 14'd1;  // [R9]
            end_hit[i]    = go && running[i] && run_left[i] <= 14'd1
                            && !repeat_hit[i];  // [R8]
        end
    end

    // run and repetition counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= '0;
            started <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                run_left[i]    <= '0;
                period_left[i] <= '0;
            end
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                if (sched_type != SCHED_SLOT || slot_arm[i] != ARM_START
                    || (wr_en && widx == PG_START + IDX_SLOT_ARM && slot_selector == SW'(i))) begin
                    running[i] <= 1'b0;  // [R1]
                    started[i] <= 1'b0;
                end else if (begin_hit[i] || repeat_hit[i]) begin
                    running[i]     <= 1'b1;  // [R16]
                    started[i]     <= 1'b1;
                    run_left[i]    <= rtcas_bcd16_bin(run_length_minutes[i]);  // [R7]
                    period_left[i] <= rtcas_bcd16_bin(repeat_period_minutes[i]);  // [R9]
                end else if (minute_tick && started[i]) begin
                    if (end_hit[i]) begin
                        running[i] <= 1'b0;  // [R8]
                    end else if (running[i]) begin
                        run_left[i] <= run_left[i] - 14'd1;
                    end
                    if (period_left[i] != '0) begin
                        period_left[i] <= period_left[i] - 14'd1;
                    end
                end
            end
        end
    end

    // power-up-system is the only trigger: running slots drive their actions
    always_comb begin
        next_action = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (running[i]) begin  // [R10]
                next_action.host  = next_action.host  || host_power_on_action[i] == ACT_ON;
                next_action.aux   = next_action.aux   || aux_power_on_action[i] == ACT_ON;
                next_action.relay = next_action.relay || relay_set_action[i] == ACT_ON;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            action_out <= '0;
        end else begin
            action_out <= next_action;  // [R11] [R12] [R13] [R16]
        end
    end

    // sticky status, write one to clear, set wins
    assign irq_event[IRQ_BEGIN] = |(begin_hit | repeat_hit);
    assign irq_event[IRQ_END]   = |end_hit;
    assign irq_event[IRQ_FAULT] = wr_en && widx == PG_START + IDX_SLOT_ARM && wbyte == ARM_START
                                  && fault[slot_selector] != '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status
                           & ~((wr_en && widx == PG_GLOB + IDX_IRQ_STATUS)
                               ? pwdata[IRQ_BITS-1:0] : '0))
                          | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_en && widx == PG_GLOB + IDX_IRQ_MASK) begin
            irq_mask <= pwdata[IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status() & irq_mask);
        end
    end

    function automatic logic [IRQ_BITS-1:0] next_irq_status();
        return (irq_status & ~((wr_en && widx == PG_GLOB + IDX_IRQ_STATUS)
                               ? pwdata[IRQ_BITS-1:0] : '0)) | irq_event;
    endfunction

    // checks
    a_arm_start_runs: assert property (@(posedge pclk) disable iff (!presetn)  // [R1]
        begin_hit[0] && !wr_en
        |=> running[0] ##1 action_out.host == (host_power_on_action[0] == ACT_ON))
        else $error("slot 0 did not start on time match");
    a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)  // [R1]
        slot_arm[0] == ARM_STOP |=> !running[0])
        else $error("stopped slot still running");
    a_start_match: assert property (@(posedge pclk) disable iff (!presetn)  // [R16]
        $rose(running[0]) |-> $past(rtc_now == start_time[0] || repeat_hit[0]))
        else $error("slot began without time match or repetition");
    a_once_ends: assert property (@(posedge pclk) disable iff (!presetn)  // [R8]
        end_hit[0] && repeat_period_minutes[0] == REPEAT_ONCE |=> !running[0] ##1 !running[0])
        else $error("single run did not end");
    a_sel_range: assert property (@(posedge pclk) disable iff (!presetn)  // [R14]
        wr_en && widx == PG_GLOB + IDX_SLOT_SELECTOR && wbyte >= 8'(SLOTS)
        |=> $stable(slot_selector))
        else $error("slot selector took an illegal value");
    a_basic_idle: assert property (@(posedge pclk) disable iff (!presetn)  // [R15]
        sched_type == SCHED_BASIC |=> running == '0 ##1 action_out == '0)
        else $error("slot scheduler active in basic mode");
    a_action_gate: assert property (@(posedge pclk) disable iff (!presetn)  // [R13]
        running == '0 |=> action_out.relay == 1'b0)
        else $error("relay action without a running slot");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(|(irq_mask & next_irq_status())))
        else $error("interrupt without an unmasked status bit");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("access phase not answered in one cycle");
    a_repeat_reload: assert property (@(posedge pclk) disable iff (!presetn)  // [R9]
        repeat_hit[0] && !wr_en
        |=> running[0] && period_left[0] == rtcas_bcd16_bin(repeat_period_minutes[0]))
        else $error("repetition did not reload the slot");
    a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)  // [R1]
        irq_event[IRQ_FAULT] |=> irq_status[IRQ_FAULT])
        else $error("arming a faulty slot did not flag it");

endmodule
